/* File: verilog/mpt_trip.sv */
`default_nettype none
module mpt_trip
  import mpt_pkg::*;
#(
  parameter int unsigned CW = 12,
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned THERM_TICKS = THERM_DELAY_TICKS,
  parameter int unsigned UNBAL_TICKS = UNBAL_DELAY_TICKS
) (
  // Clock and reset
  input  wire  logic          hclk,
  input  wire  logic          hresetn,
  // AHB-Lite slave
  input  wire  logic          hsel,
  input  wire  logic [7:0]    haddr,
  input  wire  logic [1:0]    htrans,
  input  wire  logic          hwrite,
  input  wire  logic [2:0]    hsize,
  input  wire  logic [31:0]   hwdata,
  input  wire  logic          hready,
  output logic [31:0]         hrdata,
  output logic                hreadyout,
  output logic                hresp,
  // Sensor samples and pins
  input  wire  logic [CW-1:0] phase_a,
  input  wire  logic [CW-1:0] phase_b,
  input  wire  logic [CW-1:0] phase_c,
  input  wire  logic [CW-1:0] gf_level,
  input  wire  logic          therm_hot_pin,
  input  wire  logic          therm_open_pin,
  input  wire  logic          power_ok_pin,
  input  wire  logic          test_button_pin,
  input  wire  logic          reset_button_pin,
  // Front-panel switches
  input  wire  logic [CW-1:0] full_load_sw,
  input  wire  logic [CW-1:0] gf_level_sw,
  input  wire  logic [7:0]    gf_delay_sw,
  input  wire  logic [2:0]    overload_curve_select,
  // Outputs
  output logic                relay_set_pulse,
  output logic                relay_clr_pulse,
  output logic [3:0]          fault_led,
  output logic                wd_strobe,
  output logic                irq
);
  localparam int unsigned TW = 2 * CW + 8;

  function automatic logic [CW-1:0] min3(input logic [CW-1:0] a,
                                         input logic [CW-1:0] b,
                                         input logic [CW-1:0] c);
    logic [CW-1:0] m;
    m = (a < b) ? a : b;
    return (m < c) ? m : c;
  endfunction

  // Two-flop synchronisers for every pin-level input
  logic [4:0] pin_s1, pin_s2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {reset_button_pin, test_button_pin, power_ok_pin,
                 therm_open_pin, therm_hot_pin};
      pin_s2 <= pin_s1;
    end
  end
  wire therm_hot  = pin_s2[0];
  wire therm_open = pin_s2[1];
  wire power_ok   = pin_s2[2];
  wire test_btn   = pin_s2[3];
  wire reset_btn  = pin_s2[4];

  // Millisecond tick
  logic [$clog2(TICK_CYC)-1:0] tick_cnt;
  logic tick;
  logic logic_rst;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick <= (tick_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1));
      if (tick_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1))
        tick_cnt <= '0;
      else
        tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // Watchdog: strobes come from the sequencer whenever it is out of MPT_INIT
  mpt_state_type state;
  logic [7:0] strobe_cnt, wd_cnt;
  logic       wd_fire;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strobe_cnt <= '0;
      wd_strobe  <= 1'b0;
    end else begin
      wd_strobe <= 1'b0;
      if (logic_rst)
        strobe_cnt <= '0;
      else if (tick && state != MPT_INIT) begin
        if (strobe_cnt == 8'(STROBE_TICKS - 1)) begin
          strobe_cnt <= '0;
          wd_strobe  <= 1'b1;
        end else
          strobe_cnt <= strobe_cnt + 1'b1;
      end
    end
  end
  // Independent timer: it sees the strobe and power_ok, not the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt  <= '0;
      wd_fire <= 1'b0;
    end else begin
      wd_fire <= 1'b0;
      if (wd_strobe || !power_ok)
        wd_cnt <= '0;
      else if (tick) begin
        if (wd_cnt == 8'(WDOG_TIMEOUT_TICKS - 1)) begin
          wd_cnt  <= '0;
          wd_fire <= 1'b1;
        end else
          wd_cnt <= wd_cnt + 1'b1;
      end
    end
  end
  assign logic_rst = !power_ok || wd_fire;

  // Switch storage
  logic [CW-1:0] fl_set, gfl_set;
  logic [7:0]    gfd_set;
  logic [2:0]    curve_set;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fl_set    <= '0;
      gfl_set   <= '0;
      gfd_set   <= '0;
      curve_set <= '0;
    end else if (tick) begin
      fl_set    <= full_load_sw;
      gfl_set   <= gf_level_sw;
      gfd_set   <= gf_delay_sw;
      curve_set <= overload_curve_select;
    end
  end

  // Current averaging, sampled every cycle
  logic [CW-1:0] avg_i, min_i;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      avg_i <= '0;
      min_i <= '0;
    end else begin
      avg_i <= CW'(({2'b00, phase_a} + {2'b00, phase_b}
                   + {2'b00, phase_c}) / 3);
      min_i <= min3(phase_a, phase_b, phase_c);
    end
  end

  // Fault conditions
  wire gf_present = gf_level > gfl_set;
  wire therm_trip_cond = therm_hot && !therm_open;
  wire [CW+7:0] min_load = (CW+8)'(fl_set) * (CW+8)'(MIN_LOAD_PCT);
  wire [CW+7:0] avg_pct  = (CW+8)'(avg_i) * (CW+8)'(PCT_FULL);
  wire ub_enable = avg_pct >= min_load;
  wire [CW+7:0] diff_q8 = (CW+8)'(avg_i - min_i) << 8;
  wire ub_cond = ub_enable && (avg_i != '0) &&
                 (diff_q8 > (CW+8)'(avg_i) * (CW+8)'(UNBAL_RATIO_Q8));
  wire overloaded = avg_i > fl_set;

  logic [TW-1:0] thermal;
  wire [TW-1:0] ol_limit = TW'(fl_set) * TW'(fl_set) *
                           TW'({5'd0, curve_set} + 8'd1) * TW'(8);
  wire ol_cond = thermal > ol_limit;

  // Delay counters
  logic [7:0]  gf_cnt;
  logic [15:0] th_cnt, ub_cnt;
  wire run = state == MPT_RUN;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gf_cnt <= '0;
      th_cnt <= '0;
      ub_cnt <= '0;
    end else if (logic_rst || !run) begin
      gf_cnt <= '0;
      th_cnt <= '0;
      ub_cnt <= '0;
    end else begin
      if (tick) begin
        gf_cnt <= !gf_present ? '0 :
                  (gf_cnt < gfd_set) ? gf_cnt + 1'b1 : gf_cnt;
        ub_cnt <= !ub_cond ? '0 :
                  (ub_cnt < 16'(UNBAL_TICKS)) ? ub_cnt + 1'b1 : ub_cnt;
      end
      // Missing sensor drops the count at once, not at the next tick
      if (!therm_trip_cond)
        th_cnt <= '0;
      else if (tick && th_cnt < 16'(THERM_TICKS))
        th_cnt <= th_cnt + 1'b1;
    end
  end
  wire gf_trip = gf_present && gf_cnt >= gfd_set;
  wire th_trip = th_cnt >= 16'(THERM_TICKS);
  wire ub_trip = ub_cnt >= 16'(UNBAL_TICKS);

  // Thermal integrator
  wire [TW-1:0] sq = TW'(avg_i) * TW'(avg_i);
  wire [TW-1:0] cool = thermal >> 6;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      thermal <= '0;
    else if (logic_rst)
      thermal <= '0;
    else if (tick) begin
      if (overloaded && run)
        thermal <= thermal + sq;
      else
        thermal <= thermal - cool - (cool == '0 && thermal != '0 ?
                   TW'(1) : TW'(0));
    end
  end

  // Registers
  logic [3:0] irq_stat, irq_mask;
  logic       sw_reset, sw_test;
  logic [3:0] trip_evt;

  // Sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      state <= MPT_INIT;
    else if (logic_rst)
      state <= MPT_INIT;
    else begin
      unique case (state)
        MPT_INIT: state <= MPT_RUN;
        MPT_RUN:  if (trip_evt != '0) state <= MPT_TRIP;
        MPT_TRIP: if (reset_btn || sw_reset) state <= MPT_RUN;
        default:  state <= MPT_INIT;
      endcase
    end
  end
  always_comb begin
    trip_evt = '0;
    if (run) begin
      if (test_btn || sw_test)
        trip_evt = 4'hf;
      else
        trip_evt = {th_trip, gf_trip, ub_trip, ol_cond};
    end
  end

  // Fault indicators latch until reset; relay gets pulses only
  logic [7:0] pulse_cnt;
  logic       pulse_set;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_led <= '0;
      pulse_cnt <= '0;
      pulse_set <= 1'b0;
    end else if (logic_rst) begin
      pulse_cnt <= '0;
    end else if (state == MPT_INIT) begin
      fault_led <= '0;
    end else if (run && trip_evt != '0) begin
      fault_led <= trip_evt;
      pulse_cnt <= 8'(RELAY_PULSE_CYCLES);
      pulse_set <= 1'b1;
    end else if (state == MPT_TRIP && (reset_btn || sw_reset)) begin
      fault_led <= '0;
      pulse_cnt <= 8'(RELAY_PULSE_CYCLES);
      pulse_set <= 1'b0;
    end else if (pulse_cnt != '0)
      pulse_cnt <= pulse_cnt - 1'b1;
  end
  // Latching relay: no pulse after init keeps it where power loss left it
  assign relay_set_pulse = pulse_cnt != '0 && pulse_set;
  assign relay_clr_pulse = pulse_cnt != '0 && !pulse_set;

  // AHB-Lite slave, zero wait states
  logic       dp_act, dp_wr;
  logic [7:0] dp_addr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_act  <= 1'b0;
      dp_wr   <= 1'b0;
      dp_addr <= '0;
    end else if (hready) begin
      dp_act  <= hsel && htrans[1];
      dp_wr   <= hwrite;
      dp_addr <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  wire wr = dp_act && dp_wr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_reset <= 1'b0;
      sw_test  <= 1'b0;
      irq_mask <= '0;
    end else begin
      sw_reset <= 1'b0;
      sw_test  <= 1'b0;
      if (wr && dp_addr == ADDR_CTRL) begin
        sw_reset <= hwdata[CTRL_RESET];
        sw_test  <= hwdata[CTRL_TEST];
      end
      if (wr && dp_addr == ADDR_IRQ_MASK)
        irq_mask <= hwdata[3:0];
    end
  end
  // Set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      irq_stat <= '0;
    else
      irq_stat <= (irq_stat & ~((wr && dp_addr == ADDR_IRQ_STAT) ?
                   hwdata[3:0] : 4'h0)) | trip_evt;
  end
  assign irq = |(irq_stat & irq_mask);

  always_comb begin
    hrdata = '0;
    if (dp_act && !dp_wr) begin
      unique case (dp_addr)
        ADDR_STATUS:   hrdata = {26'h0, state, fault_led};
        ADDR_IRQ_STAT: hrdata = {28'h0, irq_stat};
        ADDR_IRQ_MASK: hrdata = {28'h0, irq_mask};
        ADDR_AVG:      hrdata = 32'(avg_i);
        ADDR_THERMAL:  hrdata = 32'(thermal);
        default:       hrdata = '0;
      endcase
    end
  end

  // Assertions
  property p_gf_trip;
    @(posedge hclk) disable iff (!hresetn)
      (run && !test_btn && !sw_test && gf_trip && !logic_rst)
        |=> state == MPT_TRIP;
  endproperty
  a_gf_trip: assert property (p_gf_trip) else $error("gf trip missed");
  property p_gf_clear;
    @(posedge hclk) disable iff (!hresetn)
      (run && tick && !gf_present && !logic_rst) |=> gf_cnt == '0;
  endproperty
  a_gf_clear: assert property (p_gf_clear) else $error("gf count kept");
  property p_th_open;
    @(posedge hclk) disable iff (!hresetn)
      (therm_open && !logic_rst) |=> th_cnt == '0;
  endproperty
  a_th_open: assert property (p_th_open) else $error("no sensor counted");
  property p_trip_hold;
    @(posedge hclk) disable iff (!hresetn)
      (state == MPT_TRIP && !reset_btn && !sw_reset && !logic_rst)
        |=> state == MPT_TRIP;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("left trip");
  property p_test;
    @(posedge hclk) disable iff (!hresetn)
      (run && test_btn && !logic_rst) |=> fault_led == 4'hf && relay_set_pulse;
  endproperty
  a_test: assert property (p_test) else $error("self test failed");
  property p_pwr;
    @(posedge hclk) disable iff (!hresetn)
      !power_ok |=> state == MPT_INIT && thermal == '0;
  endproperty
  a_pwr: assert property (p_pwr) else $error("no power-fail reset");
  property p_ub_low;
    @(posedge hclk) disable iff (!hresetn)
      (!ub_enable && !logic_rst) |=> ub_cnt == '0 || !$past(tick);
  endproperty
  a_ub_low: assert property (p_ub_low) else $error("unbalance active low");
  property p_cool;
    @(posedge hclk) disable iff (!hresetn)
      (tick && !overloaded && !logic_rst) |=> thermal <= $past(thermal);
  endproperty
  a_cool: assert property (p_cool) else $error("thermal rose cooling");
  property p_th_delay;
    @(posedge hclk) disable iff (!hresetn)
      (trip_evt[FLT_TH] && !test_btn && !sw_test)
        |-> th_cnt >= 16'(THERM_TICKS);
  endproperty
  a_th_delay: assert property (p_th_delay) else $error("early therm trip");
endmodule // mpt_trip
`default_nettype wire

/* File: verilog/mpt_pkg.sv */
// Summary of operation
// - Sample phase currents continuously; compute average and minimum.
// - Ground fault only when zero-sequence level exceeds set level.
// - Ground fault and overload timing use clocked counters, not analog.
// - Thermistor below low reference trips; above high means no sensor.
// - Read all panel and option switches into internal storage.
// - Relay pulsed, indicators latched; relay keeps state through power loss.
// - Power-fail detector holds or returns the logic to start-up state.
// - Sequencer emits periodic strobes; watchdog resets when they stop.
// - Initialisation clears state, delay counters, thermal value and indicators; irq_stat and irq_mask keep theirs.
// - Ground fault and thermistor conditions advance their delay counters.
// - Unbalance trip when (avg-min)/avg exceeds threshold for a set time.
// - Square the average current and accumulate it as a thermal estimate.
// - Overload trip when thermal value exceeds the curve-selected threshold.
// - Thermal value decays over time when stopped or not overloaded.
// - Once tripped, ignore fault inputs and wait for a reset request.
// - Unbalance protection disabled below 40 percent of full-load setting.
// - Thermistor trip only after hot condition persists for 3 seconds.
// - Self-test button trips the relay and sets all four fault indicators.
`default_nettype none
package mpt_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned THERM_DELAY_S = 3;
  localparam int unsigned THERM_DELAY_TICKS = THERM_DELAY_S * 1000;
  localparam int unsigned UNBAL_DELAY_TICKS = 2000;
  localparam int unsigned MIN_LOAD_PCT = 40;
  localparam int unsigned PCT_FULL = 100;
  localparam int unsigned STROBE_TICKS = 10;
  localparam int unsigned WDOG_TIMEOUT_TICKS = 50;
  localparam int unsigned RELAY_PULSE_CYCLES = 16;
  localparam logic [7:0] UNBAL_RATIO_Q8 = 8'h40;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_AVG = 8'h10;
  localparam logic [7:0] ADDR_THERMAL = 8'h14;
  localparam int unsigned FLT_OL = 0;
  localparam int unsigned FLT_UB = 1;
  localparam int unsigned FLT_GF = 2;
  localparam int unsigned FLT_TH = 3;
  localparam int unsigned CTRL_RESET = 0;
  localparam int unsigned CTRL_TEST = 1;
  typedef enum logic [1:0] {MPT_INIT, MPT_RUN, MPT_TRIP} mpt_state_type;
endpackage : mpt_pkg
`default_nettype wire

/* File: dv/mpt_relay_model.sv */
`default_nettype none
module mpt_relay_model (
  // Coil drive
  input  wire logic hclk,
  input  wire logic set_pulse,
  input  wire logic clr_pulse,
  // Contact state
  output var  logic closed
);
  timeunit 1ns;
  timeprecision 1ps;
  // Latching coil: no reset, state survives loss of power
  initial closed = 1'b0;
  always @(posedge hclk) begin
    if (set_pulse) closed <= 1'b1;
    else if (clr_pulse) closed <= 1'b0;
  end
endmodule // mpt_relay_model
`default_nettype wire

/* File: dv/mpt_trip_tb.sv */
`default_nettype none
module mpt_trip_tb;
  import mpt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [7:0] haddr, gf_delay_sw;
  logic [1:0] htrans;
  logic [2:0] hsize, curve;
  logic [31:0] hwdata, hrdata, rd, t1;
  logic [11:0] pa, pb, pc, gfl, fl_sw, gf_sw;
  logic hot, opn, pok, tst, rst_btn, set_p, clr_p, wd_strobe, closed;
  logic [3:0] fault_led;
  int errors, n_tests, cyc;
  assign hready = hreadyout;
  mpt_trip #(.TICK_CYC(TK), .THERM_TICKS(5), .UNBAL_TICKS(5)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .phase_a(pa), .phase_b(pb), .phase_c(pc), .gf_level(gfl),
    .therm_hot_pin(hot), .therm_open_pin(opn), .power_ok_pin(pok),
    .test_button_pin(tst), .reset_button_pin(rst_btn),
    .full_load_sw(fl_sw), .gf_level_sw(gf_sw), .gf_delay_sw(gf_delay_sw),
    .overload_curve_select(curve), .relay_set_pulse(set_p),
    .relay_clr_pulse(clr_p), .fault_led(fault_led), .wd_strobe(wd_strobe),
    .irq(irq));
  mpt_relay_model i_relay (.hclk(hclk), .set_pulse(set_p),
    .clr_pulse(clr_p), .closed(closed));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, run needs about 1300 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(string what, logic exp, logic got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic ahb(logic wr, logic [7:0] a, logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic ticks(int n);
    repeat (n * TK) @(posedge hclk);
  endtask
  task automatic wait_led(int idx, int n);
    for (int i = 0; i < n * TK && fault_led[idx] !== 1'b1; i++)
      @(posedge hclk);
    check_bit("fault_led", 1'b1, fault_led[idx]);
  endtask
  task automatic set_phases(logic [11:0] a, logic [11:0] b, logic [11:0] c);
    pa <= a;
    pb <= b;
    pc <= c;
  endtask
  task automatic ctrl_reset();
    ahb(1'b1, ADDR_CTRL, 32'h1);
    ticks(2);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check_val("state", 32'h1, rd[5:4]);
  endtask
  initial begin
    errors = 0;
    n_tests = 0;
    cyc = 0;
    {hsel, hwrite, htrans, haddr, hwdata, hot, opn, tst, rst_btn} = '0;
    hsize = 3'b010;
    hresetn = 1'b0;
    pok = 1'b1;
    {pa, pb, pc, gfl} = '0;
    fl_sw = 12'h3e8;
    gf_sw = 12'h100;
    gf_delay_sw = 8'h05;
    curve = 3'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ticks(3);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check_val("status", 32'h10, rd);
    check_bit("relay", 1'b0, closed);
    ahb(1'b1, ADDR_IRQ_MASK, 32'hf);
    ahb(1'b0, ADDR_IRQ_MASK, 32'h0);
    check_val("irq_mask", 32'hf, rd);
    ahb(1'b0, 8'h20, 32'h0);
    check_val("unmapped", 32'h0, rd);
    check_bit("hresp", 1'b0, hresp);
    for (int i = 0; i < 30 * TK && wd_strobe !== 1'b1; i++) @(posedge hclk);
    check_bit("wd_strobe", 1'b1, wd_strobe);
    set_phases(12'h3e8, 12'h3e8, 12'h3e8);
    ticks(2);
    ahb(1'b0, ADDR_AVG, 32'h0);
    check_val("average", 32'h3e8, rd);
    set_phases(12'h0, 12'h0, 12'h0);
    // Interrupted fault must restart its delay count
    repeat (2) begin
      gfl <= 12'h200;
      ticks(3);
      gfl <= 12'h000;
      ticks(1);
    end
    check_bit("gf_led", 1'b0, fault_led[FLT_GF]);
    gfl <= 12'h0ff;
    ticks(8);
    check_bit("gf_led", 1'b0, fault_led[FLT_GF]);
    gfl <= 12'h200;
    wait_led(FLT_GF, 10);
    ticks(1);
    check_bit("relay", 1'b1, closed);
    check_bit("irq", 1'b1, irq);
    ahb(1'b0, ADDR_IRQ_STAT, 32'h0);
    check_bit("irq_stat", 1'b1, rd[FLT_GF]);
    hot <= 1'b1;
    set_phases(12'h3e8, 12'h3e8, 12'h1f4);
    ticks(12);
    check_bit("th_led", 1'b0, fault_led[FLT_TH]);
    check_bit("ub_led", 1'b0, fault_led[FLT_UB]);
    {hot, gfl} <= '0;
    set_phases(12'h0, 12'h0, 12'h0);
    ahb(1'b1, ADDR_IRQ_STAT, 32'hf);
    ahb(1'b1, ADDR_IRQ_MASK, 32'h0);
    check_bit("irq", 1'b0, irq);
    rst_btn <= 1'b1;
    ticks(1);
    rst_btn <= 1'b0;
    ticks(3);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check_val("state", 32'h1, rd[5:4]);
    check_bit("relay", 1'b0, closed);
    {hot, opn} <= 2'b11;
    ticks(12);
    check_bit("th_led", 1'b0, fault_led[FLT_TH]);
    opn <= 1'b0;
    ticks(2);
    check_bit("th_led", 1'b0, fault_led[FLT_TH]);
    wait_led(FLT_TH, 10);
    hot <= 1'b0;
    ctrl_reset();
    set_phases(12'h12c, 12'h12c, 12'h064);
    ticks(15);
    check_bit("ub_led", 1'b0, fault_led[FLT_UB]);
    set_phases(12'h3e8, 12'h3e8, 12'h1f4);
    wait_led(FLT_UB, 15);
    set_phases(12'h0, 12'h0, 12'h0);
    ctrl_reset();
    set_phases(12'h4b0, 12'h4b0, 12'h4b0);
    ticks(2);
    ahb(1'b0, ADDR_THERMAL, 32'h0);
    check_bit("thermal_up", 1'b1, rd > 0);
    wait_led(FLT_OL, 30);
    set_phases(12'h0, 12'h0, 12'h0);
    // Thermal value must cool below the limit, or the reset re-trips
    ticks(8);
    ctrl_reset();
    ahb(1'b0, ADDR_THERMAL, 32'h0);
    t1 = rd;
    ticks(5);
    ahb(1'b0, ADDR_THERMAL, 32'h0);
    check_bit("thermal_down", 1'b1, rd < t1);
    tst <= 1'b1;
    ticks(1);
    tst <= 1'b0;
    ticks(2);
    check_val("fault_led", 32'hf, fault_led);
    check_bit("relay", 1'b1, closed);
    ctrl_reset();
    ahb(1'b1, ADDR_CTRL, 32'h2);
    ticks(1);
    check_val("fault_led", 32'hf, fault_led);
    ctrl_reset();
    pok <= 1'b0;
    repeat (5) @(posedge hclk);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check_val("state", 32'h0, rd[5:4]);
    pok <= 1'b1;
    ticks(2);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check_val("state", 32'h1, rd[5:4]);
    report_and_stop();
  end
endmodule // mpt_trip_tb
`default_nettype wire
